/* hdl/rwc_ctl.sv */
// Control logic of a battery-backed clock: register port, time buffers, alarm, watchdog.
// Assumes an external calendar supplies int_time with sec_tick and accepts time_load.
`timescale 1ns/1ps
`default_nettype none
`include "rwc_params.svh"
module rwc_ctl #(
    parameter int RST_CYC  = `RWC_RST_CYC,
    parameter int TICK_CYC = `RWC_WD_STEP_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              power_ok,
    input  wire rwc_pkg::rwc_bus_s bus,
    input  wire rwc_pkg::rwc_time_s int_time,
    input  wire logic              sec_tick,
    output logic [7:0]             dq_o,
    output logic                   dq_oe,
    output logic                   irq_n_o,
    output logic                   irq_n_oe,
    output logic                   power_on_out_n_o,
    output logic                   power_on_out_n_oe,
    output logic                   rst_n_o,
    output logic                   rst_n_oe,
    output logic                   osc_run,
    output logic                   sqw_enable,
    output logic                   time_load,
    output rwc_pkg::rwc_time_s     time_load_val
);
    rwc_pkg::rwc_main_s q;
    rwc_pkg::rwc_main_s d;
    logic               act_wr;
    logic               act_rd;
    logic               wr;
    logic               flag_rd;
    logic               flag_clr;
    logic [3:0]         al_mode;
    logic               hit;
    logic               al_hit;
    logic               tmo;
    logic               wd_irq;
    logic               wd_rst;
    logic               te;
    logic               alarm_irq_enable;
    logic               alarm_power_enable;
    logic               watchdog_enable_bit;
    logic               watchdog_steering;
    logic               sm;
    logic               mm;
    logic               hm;
    logic               dm;

    // ==========================================================
    // Register port decode.
    assign act_wr   = power_ok && !bus.cs_n && !bus.we_n;
    assign act_rd   = power_ok && !bus.cs_n && bus.we_n && !bus.oe_n;
    assign wr       = q.wr_act && !act_wr && power_ok;
    assign flag_rd  = act_rd && (bus.addr == `RWC_ADR_FLAGS);
    assign flag_clr = q.flag_rd && !flag_rd;

    assign te  = q.ctl_b[`RWC_CB_TE];
    assign alarm_irq_enable = q.ctl_b[`RWC_CB_TIE];
    assign alarm_power_enable = q.ctl_b[`RWC_CB_TPE];
    assign watchdog_enable_bit = q.ctl_b[`RWC_CB_WDE];
    assign watchdog_steering = q.ctl_b[`RWC_CB_WDS];

    // ==========================================================
    // Alarm compare.
    assign al_mode = {q.al_dd[`RWC_AL_MASK], q.al_hour[`RWC_AL_MASK],
                      q.al_min[`RWC_AL_MASK], q.al_sec[`RWC_AL_MASK]};
    assign sm = (int_time.sec[6:0] == q.al_sec[6:0]);
    assign mm = (int_time.min[6:0] == q.al_min[6:0]);
    assign hm = (int_time.hour[5:0] == q.al_hour[5:0]);
    assign dm = q.al_dd[`RWC_AL_DYDT] ? (int_time.day[2:0] == q.al_dd[2:0])
                                      : (int_time.date[5:0] == q.al_dd[5:0]);

    always_comb begin
        case (al_mode)
            4'b1111: hit = 1'b1;
            4'b1110: hit = sm;
            4'b1100: hit = sm && mm;
            4'b1000: hit = sm && mm && hm;
            4'b0000: hit = sm && mm && hm && dm;
            default: hit = 1'b1;
        endcase
    end

    assign al_hit = sec_tick && hit;
    assign wd_irq = tmo && watchdog_enable_bit && !watchdog_steering;
    assign wd_rst = tmo && watchdog_enable_bit && watchdog_steering;

    // ==========================================================
    // Watchdog and reset stretcher.
    rwc_wdog #(
        .TICK_CYC(TICK_CYC)
    ) u_wdog (
        .clk_sys(clk_sys),
        .rst    (rst),
        .period ({q.wd_hi, q.wd_lo}),
        .reload (q.wd_reload),
        .tmo    (tmo)
    );

    rwc_stretch #(
        .RST_CYC(RST_CYC)
    ) u_stretch (
        .clk_sys(clk_sys),
        .rst    (rst),
        .hold   (!power_ok),
        .trig   (wd_rst),
        .act    (rst_n_oe)
    );

    // ==========================================================
    // Next state.
    always_comb begin
        d           = q;
        d.wr_act    = act_wr;
        d.flag_rd   = flag_rd;
        d.ld        = 1'b0;
        d.wd_reload = 1'b0;
        if (act_wr) begin
            d.wr_addr = bus.addr;
            d.wr_data = bus.dq_i;
        end
        if (sec_tick && te) begin
            d.ext = int_time;
        end
        if (wr) begin
            case (q.wr_addr)
                `RWC_ADR_SEC:     d.ext.sec  = q.wr_data;
                `RWC_ADR_MIN:     d.ext.min  = q.wr_data;
                `RWC_ADR_HOUR:    d.ext.hour = q.wr_data;
                `RWC_ADR_DAY:     d.ext.day  = q.wr_data;
                `RWC_ADR_DATE:    d.ext.date = q.wr_data;
                `RWC_ADR_AL_SEC:  d.al_sec   = q.wr_data;
                `RWC_ADR_AL_MIN:  d.al_min   = q.wr_data;
                `RWC_ADR_AL_HOUR: d.al_hour  = q.wr_data;
                `RWC_ADR_AL_DD:   d.al_dd    = q.wr_data;
                `RWC_ADR_WD_LO: begin
                    d.wd_lo     = q.wr_data;
                    d.wd_reload = 1'b1;
                end
                `RWC_ADR_WD_HI: begin
                    d.wd_hi     = q.wr_data;
                    d.wd_reload = 1'b1;
                end
                `RWC_ADR_CTL_B: begin
                    d.ctl_b = q.wr_data;
                    if (te && !q.wr_data[`RWC_CB_TE]) begin
                        d.ext = int_time;
                    end
                    if (!te && q.wr_data[`RWC_CB_TE]) begin
                        d.ld = 1'b1;
                    end
                end
                `RWC_ADR_CTL_A:   d.ctl_a    = q.wr_data;
                default: begin
                end
            endcase
        end
        if (wd_rst) begin
            d.ctl_b[`RWC_CB_WDE] = 1'b0;
        end
        d.fl_al  = (q.fl_al && !flag_clr) || al_hit;
        d.fl_wd  = (q.fl_wd && !flag_clr) || tmo;
        d.fl_irq = (q.fl_irq && !flag_clr) || (al_hit && alarm_irq_enable) || wd_irq;
        case (bus.addr)
            `RWC_ADR_SEC:     d.dq = q.ext.sec;
            `RWC_ADR_MIN:     d.dq = q.ext.min;
            `RWC_ADR_HOUR:    d.dq = q.ext.hour;
            `RWC_ADR_DAY:     d.dq = q.ext.day;
            `RWC_ADR_DATE:    d.dq = q.ext.date;
            `RWC_ADR_AL_SEC:  d.dq = q.al_sec;
            `RWC_ADR_AL_MIN:  d.dq = q.al_min;
            `RWC_ADR_AL_HOUR: d.dq = q.al_hour;
            `RWC_ADR_AL_DD:   d.dq = q.al_dd;
            `RWC_ADR_WD_LO:   d.dq = q.wd_lo;
            `RWC_ADR_WD_HI:   d.dq = q.wd_hi;
            `RWC_ADR_FLAGS:   d.dq = {q.fl_irq, 5'h00, q.fl_wd, q.fl_al};
            `RWC_ADR_CTL_B:   d.dq = q.ctl_b;
            `RWC_ADR_CTL_A:   d.dq = q.ctl_a;
            default:          d.dq = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.ctl_a <= `RWC_CTL_A_RST;
            q.ctl_b <= `RWC_CTL_B_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs.
    assign dq_o              = q.dq;
    assign dq_oe             = act_rd;
    assign irq_n_o           = 1'b0;
    assign irq_n_oe          = q.fl_irq && power_ok;
    assign power_on_out_n_o  = 1'b0;
    assign power_on_out_n_oe = q.fl_al && alarm_power_enable;
    assign rst_n_o           = 1'b0;
    assign osc_run           = !q.ctl_a[`RWC_CA_OSC_N];
    assign sqw_enable        = !q.ctl_a[`RWC_CA_SQW_N];
    assign time_load         = q.ld;
    assign time_load_val     = q.ext;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_pf_float;
        !power_ok |-> !dq_oe && !irq_n_oe;
    endproperty
    a_pf_float: assert property (p_pf_float) else $error("pins driven in power fail");

    property p_pf_rst;
        !power_ok |=> rst_n_oe;
    endproperty
    a_pf_rst: assert property (p_pf_rst) else $error("reset not low in power fail");

    property p_osc;
        wr && q.wr_addr == `RWC_ADR_CTL_A && q.wr_data[`RWC_CA_OSC_N] |=> !osc_run;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator kept running");

    property p_freeze;
        !te && !wr |=> $stable(q.ext);
    endproperty
    a_freeze: assert property (p_freeze) else $error("time moved while frozen");

    property p_load;
        wr && q.wr_addr == `RWC_ADR_CTL_B && !te && q.wr_data[`RWC_CB_TE]
            |=> time_load ##1 !time_load;
    endproperty
    a_load: assert property (p_load) else $error("time load pulse wrong");

    property p_sec_alarm;
        sec_tick && al_mode == 4'b1111 |=> q.fl_al;
    endproperty
    a_sec_alarm: assert property (p_sec_alarm) else $error("per second alarm missed");

    property p_alarm_irq;
        sec_tick && al_mode == 4'b1111 && alarm_irq_enable && power_ok ##1 power_ok |-> irq_n_oe;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm irq not driven");

    property p_wd_irq;
        tmo && watchdog_enable_bit && !watchdog_steering |=> q.fl_irq && q.fl_wd;
    endproperty
    a_wd_irq: assert property (p_wd_irq) else $error("watchdog irq flags missing");

    property p_wd_rst;
        tmo && watchdog_enable_bit && watchdog_steering |=> rst_n_oe && !watchdog_enable_bit && q.fl_wd;
    endproperty
    a_wd_rst: assert property (p_wd_rst) else $error("watchdog reset missing");

    property p_clr;
        flag_clr && !sec_tick && !tmo |=> !q.fl_al && !q.fl_wd && !q.fl_irq;
    endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared by read");

    property p_pf_ctl;
        !power_ok |=> $stable(q.ctl_a);
    endproperty
    a_pf_ctl: assert property (p_pf_ctl) else $error("register written in power fail");

    property p_pf_load;
        !power_ok |=> !time_load;
    endproperty
    a_pf_load: assert property (p_pf_load) else $error("time load in power fail");

    property p_copy;
        sec_tick && te && !wr |=> q.ext == $past(int_time);
    endproperty
    a_copy: assert property (p_copy) else $error("time not copied on tick");

    property p_capture;
        wr && q.wr_addr == `RWC_ADR_CTL_B && te && !q.wr_data[`RWC_CB_TE]
            |=> !te && q.ext == $past(int_time);
    endproperty
    a_capture: assert property (p_capture) else $error("time not captured at halt");

    property p_ld_wr;
        !wr |=> !time_load;
    endproperty
    a_ld_wr: assert property (p_ld_wr) else $error("time load without write");

    property p_bad_mask;
        sec_tick && !(al_mode inside {4'b1110, 4'b1100, 4'b1000, 4'b0000}) |=> q.fl_al;
    endproperty
    a_bad_mask: assert property (p_bad_mask) else $error("odd mask not per second");

    property p_sec_miss;
        sec_tick && !q.fl_al && al_mode == 4'b1110
            && int_time.sec[6:0] != q.al_sec[6:0] |=> !q.fl_al;
    endproperty
    a_sec_miss: assert property (p_sec_miss) else $error("alarm on seconds miss");

    property p_min_miss;
        sec_tick && !q.fl_al && al_mode == 4'b1100
            && int_time.min[6:0] != q.al_min[6:0] |=> !q.fl_al;
    endproperty
    a_min_miss: assert property (p_min_miss) else $error("alarm on minutes miss");

    property p_hour_miss;
        sec_tick && !q.fl_al && al_mode == 4'b1000
            && int_time.hour[5:0] != q.al_hour[5:0] |=> !q.fl_al;
    endproperty
    a_hour_miss: assert property (p_hour_miss) else $error("alarm on hours miss");

    property p_day_miss;
        sec_tick && !q.fl_al && al_mode == 4'b0000 && q.al_dd[`RWC_AL_DYDT]
            && int_time.day[2:0] != q.al_dd[2:0] |=> !q.fl_al;
    endproperty
    a_day_miss: assert property (p_day_miss) else $error("alarm on weekday miss");

    property p_date_miss;
        sec_tick && !q.fl_al && al_mode == 4'b0000 && !q.al_dd[`RWC_AL_DYDT]
            && int_time.date[5:0] != q.al_dd[5:0] |=> !q.fl_al;
    endproperty
    a_date_miss: assert property (p_date_miss) else $error("alarm on date miss");

    property p_no_tick;
        !sec_tick && !q.fl_al |=> !q.fl_al;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("alarm flag set between ticks");

    property p_pwr_gate;
        !alarm_power_enable |-> !power_on_out_n_oe;
    endproperty
    a_pwr_gate: assert property (p_pwr_gate) else $error("power pin not gated");

    property p_irq_rel;
        !q.fl_irq |-> !irq_n_oe;
    endproperty
    a_irq_rel: assert property (p_irq_rel) else $error("irq pin not released");

    property p_wd_flag;
        tmo |=> q.fl_wd;
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag not set");

    property p_wd_quiet;
        tmo && !watchdog_enable_bit && !sec_tick && !q.fl_irq |=> !q.fl_irq;
    endproperty
    a_wd_quiet: assert property (p_wd_quiet) else $error("irq flag set while disabled");

    property p_keep;
        q.fl_wd && !flag_clr |=> q.fl_wd;
    endproperty
    a_keep: assert property (p_keep) else $error("watchdog flag lost without read");
endmodule
`default_nettype wire

/* hdl/rwc_params.svh */
// Constants of the clock control block: offsets, field positions, reset values, counts.
// Assumes a 50 MHz system clock and an 8-bit asynchronous register port.
`ifndef RWC_PARAMS_SVH
`define RWC_PARAMS_SVH
`define RWC_CLK_HZ      50000000
`define RWC_RST_MIN_MS  40
`define RWC_RST_CYC     (`RWC_RST_MIN_MS * (`RWC_CLK_HZ / 1000))
`define RWC_WD_STEP_MS  10
`define RWC_WD_STEP_CYC (`RWC_WD_STEP_MS * (`RWC_CLK_HZ / 1000))
`define RWC_ADR_SEC     5'h00
`define RWC_ADR_MIN     5'h01
`define RWC_ADR_HOUR    5'h02
`define RWC_ADR_DAY     5'h03
`define RWC_ADR_DATE    5'h04
`define RWC_ADR_AL_SEC  5'h08
`define RWC_ADR_AL_MIN  5'h09
`define RWC_ADR_AL_HOUR 5'h0a
`define RWC_ADR_AL_DD   5'h0b
`define RWC_ADR_WD_LO   5'h0c
`define RWC_ADR_WD_HI   5'h0d
`define RWC_ADR_FLAGS   5'h0e
`define RWC_ADR_CTL_B   5'h0f
`define RWC_ADR_CTL_A   5'h10
`define RWC_CB_TE       7
`define RWC_CB_WDS      5
`define RWC_CB_WDE      4
`define RWC_CB_KIE      2
`define RWC_CB_TPE      1
`define RWC_CB_TIE      0
`define RWC_CA_OSC_N    7
`define RWC_CA_SQW_N    6
`define RWC_FL_IRQ      7
`define RWC_FL_WD       1
`define RWC_FL_AL       0
`define RWC_AL_MASK     7
`define RWC_AL_DYDT     6
`define RWC_CTL_A_RST   8'h00
`define RWC_CTL_B_RST   8'h80
`endif

/* hdl/rwc_pkg.sv */
// Types shared by the clock control block.
// Assumes rwc_params.svh supplies the numeric constants.
package rwc_pkg;
    // Asynchronous register port pins, sampled on the system clock.
    typedef struct packed {
        logic       cs_n;
        logic       oe_n;
        logic       we_n;
        logic [4:0] addr;
        logic [7:0] dq_i;
    } rwc_bus_s;
    // Time of day and date, BCD, 24-hour.
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] date;
    } rwc_time_s;
    typedef struct packed {
        rwc_time_s  ext;
        logic [7:0] al_sec;
        logic [7:0] al_min;
        logic [7:0] al_hour;
        logic [7:0] al_dd;
        logic [7:0] wd_lo;
        logic [7:0] wd_hi;
        logic [7:0] ctl_a;
        logic [7:0] ctl_b;
        logic       fl_al;
        logic       fl_wd;
        logic       fl_irq;
        logic       wr_act;
        logic [4:0] wr_addr;
        logic [7:0] wr_data;
        logic       flag_rd;
        logic [7:0] dq;
        logic       ld;
        logic       wd_reload;
    } rwc_main_s;
    typedef struct packed {
        logic [15:0] cnt;
        logic [31:0] pre;
        logic        tmo;
    } rwc_wdog_s;
    typedef struct packed {
        logic [31:0] cnt;
        logic        act;
    } rwc_stretch_s;
endpackage

/* hdl/rwc_stretch.sv */
// Reset stretcher: holds its output while hold is high, then for RST_CYC cycles more.
// Assumes hold and trig are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "rwc_params.svh"
module rwc_stretch #(
    parameter int RST_CYC = `RWC_RST_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic hold,
    input  wire logic trig,
    output logic      act
);
    rwc_pkg::rwc_stretch_s q;
    rwc_pkg::rwc_stretch_s d;

    // ==========================================================
    // Countdown after the last hold or trigger.
    always_comb begin
        d = q;
        if (hold || trig) begin
            d.cnt = 32'(RST_CYC);
        end else if (q.cnt != 32'h0000_0000) begin
            d.cnt = q.cnt - 32'h0000_0001;
        end
        d.act = (d.cnt != 32'h0000_0000);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q.cnt <= 32'(RST_CYC);
            q.act <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign act = q.act;

    property p_hold;
        @(posedge clk_sys) disable iff (rst) hold |=> act;
    endproperty
    a_hold: assert property (p_hold) else $error("reset output not held during hold");
endmodule
`default_nettype wire

/* hdl/rwc_wdog.sv */
// BCD watchdog counter stepping at a 10 ms tick; pulses tmo on expiry.
// Assumes period is stable except around a reload pulse.
`timescale 1ns/1ps
`default_nettype none
`include "rwc_params.svh"
module rwc_wdog #(
    parameter int TICK_CYC = `RWC_WD_STEP_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [15:0] period,
    input  wire logic        reload,
    output logic             tmo
);
    rwc_pkg::rwc_wdog_s q;
    rwc_pkg::rwc_wdog_s d;
    logic               tick;

    // ==========================================================
    // Four-digit BCD decrement.
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    assign tick = (q.pre == 32'(TICK_CYC - 1));

    always_comb begin
        d     = q;
        d.tmo = 1'b0;
        d.pre = tick ? 32'h0000_0000 : q.pre + 32'h0000_0001;
        if (reload || period == 16'h0000) begin
            d.cnt = period;
            d.pre = 32'h0000_0000;
        end else if (tick) begin
            if (q.cnt <= 16'h0001) begin
                d.tmo = 1'b1;
                d.cnt = period;
            end else begin
                d.cnt = bcd_dec(q.cnt);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tmo = q.tmo;

    property p_reload;
        @(posedge clk_sys) disable iff (rst) reload |=> q.cnt == $past(period);
    endproperty
    a_reload: assert property (p_reload) else $error("write did not reload watchdog");
    property p_stop;
        @(posedge clk_sys) disable iff (rst) (period == 16'h0000) [*2] |=> !tmo;
    endproperty
    a_stop: assert property (p_stop) else $error("watchdog expired while stopped");
endmodule
`default_nettype wire

/* sim/rwc_ctl_tb.sv */
// Self-checking testbench of the clock control block.
// Assumes the host model rwc_host and shortened reset and tick counts.
`timescale 1ns/1ps
`default_nettype none
module rwc_ctl_tb;
    localparam int RC = 20;
    localparam int TC = 4;
    logic               clk_sys  = 1'b0;
    logic               rst      = 1'b1;
    logic               power_ok = 1'b1;
    logic               sec_tick = 1'b0;
    rwc_pkg::rwc_time_s int_time = '0;
    rwc_pkg::rwc_bus_s  bus;
    rwc_pkg::rwc_time_s tl_src;
    rwc_pkg::rwc_time_s tl_val;
    logic [7:0]         dq_o;
    logic [7:0]         rv;
    logic [2:0]         od_lvl;
    logic               dq_oe;
    logic               irq_n_oe;
    logic               pwr_oe;
    logic               rst_n_oe;
    logic               osc_run;
    logic               sqw_enable;
    logic               time_load;
    logic [32:0]        al [14];
    int                 n_fail     = 0;
    int                 num_checks = 0;
    int                 tl_cnt     = 0;
    int                 cyc        = 0;
    int                 gap;
    int                 t0;

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    always @(posedge clk_sys) if (time_load === 1'b1) begin
        tl_cnt <= tl_cnt + 1;
        tl_val <= tl_src;
    end

    rwc_host host (.clk_sys(clk_sys), .bus(bus), .dq_o(dq_o));
    rwc_ctl #(.RST_CYC(RC), .TICK_CYC(TC)) dut (
        .clk_sys(clk_sys), .rst(rst), .power_ok(power_ok), .bus(bus),
        .int_time(int_time), .sec_tick(sec_tick), .dq_o(dq_o), .dq_oe(dq_oe),
        .irq_n_o(od_lvl[0]), .irq_n_oe(irq_n_oe), .power_on_out_n_o(od_lvl[1]),
        .power_on_out_n_oe(pwr_oe), .rst_n_o(od_lvl[2]), .rst_n_oe(rst_n_oe),
        .osc_run(osc_run), .sqw_enable(sqw_enable), .time_load(time_load),
        .time_load_val(tl_src));

    // ============================================================
    // Checking tasks
    task automatic chkb(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chkv(input string nm, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e, input string nm);
        host.rd(a, rv);
        chkv(nm, {32'h0, e}, {32'h0, rv});
    endtask
    task automatic rd_oe(input logic [4:0] a, input logic e);
        fork
            host.rd(a, rv);
            begin
                repeat (2) @(posedge clk_sys);
                #1 chkb("data enable", e, dq_oe);
            end
        join
    endtask
    task automatic tick;
        @(posedge clk_sys) sec_tick <= 1'b1;
        @(posedge clk_sys) sec_tick <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wait_lvl(input bit use_rst, input logic lvl, output int n);
        n = 0;
        while (((use_rst ? rst_n_oe : irq_n_oe) !== lvl) && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic test_done;
        $display("Checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end

    // ============================================================
    // Test sequence
    initial begin
        al = '{{32'h8080_8080, 1'b1}, {32'h4680_8080, 1'b1}, {32'h4780_8080, 1'b0},
               {32'h4630_8080, 1'b1}, {32'h4631_8080, 1'b0}, {32'h4630_1280, 1'b1},
               {32'h4630_1380, 1'b0}, {32'h4630_1207, 1'b1}, {32'h4630_1208, 1'b0},
               {32'h4630_1242, 1'b1}, {32'h4630_1243, 1'b0}, {32'h8031_8080, 1'b1},
               {32'h4680_1280, 1'b1}, {32'h8080_1280, 1'b1}};
        repeat (6) @(posedge clk_sys);
        chkb("reset pin in reset", 1'b1, rst_n_oe);
        rst <= 1'b0;
        wait_lvl(1'b1, 1'b0, gap);
        chkb("reset stretch", 1'b1, gap >= RC && gap <= RC + 3);
        rchk(5'h0f, 8'h80, "control_b reset");
        rchk(5'h10, 8'h00, "control_a reset");
        rchk(5'h0c, 8'h00, "wd low reset");
        rchk(5'h0e, 8'h00, "flags idle");
        rchk(5'h1f, 8'h00, "unmapped read");
        chkb("osc run", 1'b1, osc_run);
        chkb("sqw run", 1'b1, sqw_enable);
        host.wr(5'h10, 8'h80);
        chkb("osc stop", 1'b0, osc_run);
        host.wr(5'h10, 8'h40);
        chkb("osc restart", 1'b1, osc_run);
        chkb("sqw stop", 1'b0, sqw_enable);
        rd_oe(5'h10, 1'b1);
        power_ok <= 1'b0;
        host.wr(5'h10, 8'h00);
        rd_oe(5'h10, 1'b0);
        chkb("reset pin in fail", 1'b1, rst_n_oe);
        power_ok <= 1'b1;
        wait_lvl(1'b1, 1'b0, gap);
        chkb("supply stretch", 1'b1, gap >= RC && gap <= RC + 3);
        rchk(5'h10, 8'h40, "refused write");
        int_time <= '{8'h45, 8'h30, 8'h12, 8'h02, 8'h07};
        tick();
        rchk(5'h00, 8'h45, "seconds copy");
        host.wr(5'h0f, 8'h00);
        int_time.sec <= 8'h46;
        tick();
        rchk(5'h00, 8'h45, "seconds frozen");
        host.wr(5'h00, 8'h59);
        host.wr(5'h02, 8'h23);
        host.wr(5'h0f, 8'h80);
        @(posedge clk_sys);
        chkb("one load", 1'b1, tl_cnt == 1);
        chkv("load value", 40'h5930_2302_07, tl_val);
        tick();
        rchk(5'h00, 8'h46, "resumed");
        host.wr(5'h0f, 8'h83);
        foreach (al[i]) begin
            for (int k = 0; k < 4; k++) host.wr(5'(8 + k), al[i][32 - 8 * k -: 8]);
            host.rd(5'h0e, rv);
            tick();
            chkb("alarm irq pin", al[i][0], irq_n_oe);
            chkb("alarm power pin", al[i][0], pwr_oe);
            rchk(5'h0e, {al[i][0], 6'h00, al[i][0]}, "alarm flags");
            chkb("irq released", 1'b0, irq_n_oe);
        end
        rchk(5'h0e, 8'h00, "no tick no alarm");
        host.wr(5'h0f, 8'h80);
        tick();
        chkb("irq gated", 1'b0, irq_n_oe);
        chkb("power gated", 1'b0, pwr_oe);
        rchk(5'h0e, 8'h01, "alarm only");
        host.wr(5'h0f, 8'h90);
        host.wr(5'h0c, 8'h10);
        wait_lvl(1'b0, 1'b1, gap);
        t0 = cyc;
        chkb("wd period", 1'b1, gap >= 8 * TC && gap <= 11 * TC);
        power_ok <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chkb("irq float", 1'b0, irq_n_oe);
        @(posedge clk_sys);
        power_ok <= 1'b1;
        rchk(5'h0e, 8'h82, "wd irq flags");
        chkb("wd irq released", 1'b0, irq_n_oe);
        wait_lvl(1'b0, 1'b1, gap);
        chkb("wd restart", 1'b1, cyc - t0 >= 9 * TC && cyc - t0 <= 11 * TC);
        host.rd(5'h0e, rv);
        repeat (6 * TC) @(posedge clk_sys);
        host.wr(5'h0d, 8'h00);
        wait_lvl(1'b0, 1'b1, gap);
        chkb("wd write reload", 1'b1, gap >= 8 * TC && gap <= 11 * TC);
        host.wr(5'h0c, 8'h00);
        host.rd(5'h0e, rv);
        repeat (100) @(posedge clk_sys);
        rchk(5'h0e, 8'h00, "wd stopped");
        host.wr(5'h0f, 8'h80);
        host.wr(5'h0c, 8'h05);
        repeat (40) @(posedge clk_sys);
        chkb("wd no irq", 1'b0, irq_n_oe);
        rchk(5'h0e, 8'h02, "wd flag only");
        host.wr(5'h0f, 8'hb0);
        host.wr(5'h0c, 8'h05);
        wait_lvl(1'b1, 1'b1, gap);
        chkb("wd reset start", 1'b1, gap >= 3 * TC && gap <= 6 * TC);
        chkv("pin drive levels", 40'h0, {37'h0, od_lvl});
        wait_lvl(1'b1, 1'b0, gap);
        chkb("wd reset width", 1'b1, gap >= RC - 1 && gap <= RC + 3);
        rchk(5'h0f, 8'ha0, "wd enable cleared");
        rchk(5'h0e, 8'h02, "wd reset flags");
        rchk(5'h0c, 8'h05, "wd low value");
        test_done();
    end
endmodule
`default_nettype wire

/* sim/rwc_host.sv */
// Host processor model for the bytewide register port of the clock control block.
// Assumes a free-running clk_sys; the testbench top calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module rwc_host (
    input  wire logic          clk_sys,
    output var rwc_pkg::rwc_bus_s bus,
    input  wire logic [7:0]    dq_o
);
    // ============================================================
    // Bus cycles
    initial bus = '{1'b1, 1'b1, 1'b1, 5'h1f, 8'h00};
    // Write held for two samples, then released; released data shows its inverse.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{1'b0, 1'b1, 1'b0, a, d};
        repeat (2) @(posedge clk_sys);
        bus <= '{1'b1, 1'b1, 1'b1, a, ~d};
        repeat (2) @(posedge clk_sys);
    endtask
    // Read ends by a rising chip select, then waits for the flags to settle.
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{1'b0, 1'b0, 1'b1, a, ~bus.dq_i};
        repeat (3) @(posedge clk_sys);
        d = dq_o;
        bus <= '{1'b1, 1'b1, 1'b1, a, ~bus.dq_i};
        repeat (2) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
